// ===== hdl/lutr_tile.sv
/*
  Logic tile whose two function generators act as logic or as small RAM:
  two 16x1, one 32x1, or one 16x1 dual-port array; edge or level write.
  Assumes synchronous inputs on core_clk, tile clock sampled as a level,
  configuration load pulsed by surrounding logic before use.
*/
// Overview of operation
// - two independent 16x1 arrays, shared or separate address
// - one 32x1 array, one data in/out
// - one generator RAM, other five-input logic
// - edge mode writes on tile edge, enable-gated
// - level mode writes while strobe is high
// - one timing mode for both generators
// - single port shares read and write address
// - dual port: one write, two read ports
// - simultaneous read and write, any addresses
// - reads identical in every mode except deep, muxed by the top bit
// - four input lines address each array
// - control pins become data and write enable
// - second data input is fifth address bit
// - cell data direct or into tile flops
// - configuration loads initial values; no default, cells unset until load
// - global reset leaves contents untouched
`timescale 1ns/1ps
`default_nettype none
`include "lutr_cfg.svh"

module lutr_tile
  import lutr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  // configuration load strobe and initial contents
  input wire logic cfgLoad,
  input wire logic [`LUTR_DEPTH-1:0] cfgInitA,
  input wire logic [`LUTR_DEPTH-1:0] cfgInitB,
  // generator use: memory when set, logic when clear
  input wire logic cfgMemA,
  input wire logic cfgMemB,
  input wire logic [`LUTR_FUNC_W-1:0] cfgFuncA,
  input wire logic [`LUTR_FUNC_W-1:0] cfgFuncB,
  // organisation and timing
  input wire lutr_org_e cfgOrg,
  input wire lutr_time_e cfgTiming,
  input wire logic cfgClkFall,
  input wire logic cfgSharedAddr,
  // tile clock as a sampled level
  input wire logic tileClk,
  // generator inputs
  input wire logic [`LUTR_ADDR_W-1:0] lutAAddr,
  input wire logic [`LUTR_ADDR_W-1:0] lutBAddr,
  // tile control pins
  input wire logic ctrlAPin,
  input wire logic ctrlBPin,
  input wire logic ctrlCPin,
  // generator outputs and tile flip-flops
  output logic lutAOut,
  output logic lutBOut,
  output logic tileRegA,
  output logic tileRegB,
  output logic writeSeen
);

  lutr_state_s state;
  lutr_state_s next_state;

  // control pins in their memory roles
  logic writeDataFirst;
  logic writeDataSecond;
  logic writeEnable;

  // derived mode and timing terms
  lutr_org_e orgEff;
  logic bothMem;
  logic tileEdge;
  logic wrGate;

  // per-generator memory ports
  logic memLoad;
  logic [`LUTR_DEPTH-1:0] loadData [`LUTR_GENS];
  logic wrEn [`LUTR_GENS];
  logic [`LUTR_ADDR_W-1:0] wrAddr [`LUTR_GENS];
  logic wrData [`LUTR_GENS];
  logic [`LUTR_ADDR_W-1:0] rdAddr [`LUTR_GENS];
  logic rdData [`LUTR_GENS];

  // logic-mode results and combined outputs
  logic funcA;
  logic funcB;
  logic genA;
  logic genB;

  assign writeDataFirst = ctrlAPin;
  assign writeDataSecond = ctrlBPin;
  assign writeEnable = ctrlCPin;

  // wide orgs only when both generators are memory
  assign bothMem = cfgMemA & cfgMemB;
  always_comb begin
    if (bothMem) begin
      orgEff = cfgOrg;
    end else begin
      orgEff = LUTR_ORG_SPLIT;
    end
  end

  always_comb begin
    if (cfgClkFall) begin
      tileEdge = state.tileClkPrev & ~tileClk;
    end else begin
      tileEdge = ~state.tileClkPrev & tileClk;
    end
  end

  always_comb begin
    unique case (cfgTiming)
      LUTR_TIME_EDGE: begin
        wrGate = tileEdge & writeEnable;
      end
      LUTR_TIME_LEVEL: begin
        wrGate = writeEnable;
      end
    endcase
  end

  assign memLoad = cfgLoad;
  assign loadData[`LUTR_GEN_A] = cfgInitA;
  assign loadData[`LUTR_GEN_B] = cfgInitB;

  // write and read steering per organisation
  always_comb begin
    wrEn[`LUTR_GEN_A] = 1'h0;
    wrEn[`LUTR_GEN_B] = 1'h0;
    wrAddr[`LUTR_GEN_A] = lutAAddr;
    wrAddr[`LUTR_GEN_B] = lutBAddr;
    wrData[`LUTR_GEN_A] = writeDataFirst;
    wrData[`LUTR_GEN_B] = writeDataSecond;
    rdAddr[`LUTR_GEN_A] = lutAAddr;
    rdAddr[`LUTR_GEN_B] = lutBAddr;
    unique case (orgEff)
      LUTR_ORG_SPLIT: begin
        wrEn[`LUTR_GEN_A] = cfgMemA & wrGate;
        wrEn[`LUTR_GEN_B] = cfgMemB & wrGate;
        if (cfgSharedAddr) begin
          wrAddr[`LUTR_GEN_B] = lutAAddr;
          rdAddr[`LUTR_GEN_B] = lutAAddr;
        end
      end
      LUTR_ORG_DEEP: begin
        wrEn[`LUTR_GEN_A] = wrGate & ~writeDataSecond;
        wrEn[`LUTR_GEN_B] = wrGate & writeDataSecond;
        wrAddr[`LUTR_GEN_B] = lutAAddr;
        wrData[`LUTR_GEN_B] = writeDataFirst;
        rdAddr[`LUTR_GEN_B] = lutAAddr;
      end
      LUTR_ORG_DUAL: begin
        wrEn[`LUTR_GEN_A] = wrGate;
        wrEn[`LUTR_GEN_B] = wrGate;
        wrAddr[`LUTR_GEN_B] = lutAAddr;
        wrData[`LUTR_GEN_B] = writeDataFirst;
        rdAddr[`LUTR_GEN_B] = lutBAddr;
      end
      // illegal organisation code: no writes
      default: begin
      end
    endcase
  end

  generate
    for (genvar g = 0; g < `LUTR_GENS; g++) begin : gen_array
      lutr_mem u_mem (
        .core_clk(core_clk),
        .loadEn(memLoad),
        .loadData(loadData[g]),
        .wrEn(wrEn[g]),
        .wrAddr(wrAddr[g]),
        .wrData(wrData[g]),
        .rdAddr(rdAddr[g]),
        .rdData(rdData[g])
      );
    end
  endgenerate

  assign funcA = cfgFuncA[{writeDataSecond, lutAAddr}];
  assign funcB = cfgFuncB[{writeDataSecond, lutBAddr}];

  // same read path in every mode except deep, where the top bit selects the array
  always_comb begin
    genA = cfgMemA ? rdData[`LUTR_GEN_A] : funcA;
    genB = cfgMemB ? rdData[`LUTR_GEN_B] : funcB;
    // deep mode output follows top bit
    if (orgEff == LUTR_ORG_DEEP) begin
      genA = writeDataSecond ? rdData[`LUTR_GEN_B] : rdData[`LUTR_GEN_A];
      genB = genA;
    end
  end

  assign lutAOut = genA;
  assign lutBOut = genB;

  // tile flip-flops and edge history
  always_comb begin
    next_state = state;
    next_state.tileClkPrev = tileClk;
    // capture cell data on tile edge
    if (tileEdge) begin
      next_state.tileRegA = genA;
      next_state.tileRegB = genB;
    end
    next_state.writeSeen = wrGate & (cfgMemA | cfgMemB) & ~cfgLoad;
    if (rst) begin
      next_state.tileClkPrev = `LUTR_CLK_PREV_RST;
      next_state.tileRegA = `LUTR_REG_RST;
      next_state.tileRegB = `LUTR_REG_RST;
      next_state.writeSeen = `LUTR_REG_RST;
    end
  end

  // single register of the tile state
  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

  // registered outputs
  assign tileRegA = state.tileRegA;
  assign tileRegB = state.tileRegB;
  assign writeSeen = state.writeSeen;

endmodule // lutr_tile

`default_nettype wire

// ===== hdl/lutr_cfg.svh
/*
  Constants for the look-up-table RAM tile: geometry and reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef LUTR_CFG_SVH
`define LUTR_CFG_SVH

// one function generator: 4 address lines, 16 one-bit cells
`define LUTR_ADDR_W 4
`define LUTR_DEPTH 16
// logic-mode truth table of five inputs
`define LUTR_FUNC_IN 5
`define LUTR_FUNC_W 32
// number of function generators in one tile
`define LUTR_GENS 2
// generator indices
`define LUTR_GEN_A 0
`define LUTR_GEN_B 1
// reset values of the tile flip-flops
`define LUTR_REG_RST 1'h0
`define LUTR_CLK_PREV_RST 1'h0
// default cell value, not applied by the design: cells stay unset until load
`define LUTR_INIT_DEFAULT 16'h0000

`endif

// ===== hdl/lutr_pkg.sv
/*
  Types for the look-up-table RAM tile: organisation and timing modes,
  and the state records of the tile and of one memory array.
  Assumes lutr_cfg.svh is on the include path.
*/
`include "lutr_cfg.svh"

package lutr_pkg;

  // memory organisation of the two generators
  typedef enum logic [1:0] {
    LUTR_ORG_SPLIT,
    LUTR_ORG_DEEP,
    LUTR_ORG_DUAL
  } lutr_org_e;

  // write timing, shared by both generators
  typedef enum logic {
    LUTR_TIME_EDGE,
    LUTR_TIME_LEVEL
  } lutr_time_e;

  // registered state of the tile
  typedef struct packed {
    logic tileClkPrev;
    logic tileRegA;
    logic tileRegB;
    logic writeSeen;
  } lutr_state_s;

  // registered state of one 16x1 array
  typedef struct packed {
    logic [`LUTR_DEPTH-1:0] cells;
  } lutr_mem_s;

endpackage

// ===== hdl/lutr_mem.sv
/*
  One 16x1 memory array of a function generator: load port, one write
  port and one read port that follows its address without a clock.
  Assumes a single clock; no reset reaches the cells.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lutr_cfg.svh"

module lutr_mem
  import lutr_pkg::*;
(
  input wire logic core_clk,
  input wire logic loadEn,
  input wire logic [`LUTR_DEPTH-1:0] loadData,
  input wire logic wrEn,
  input wire logic [`LUTR_ADDR_W-1:0] wrAddr,
  input wire logic wrData,
  input wire logic [`LUTR_ADDR_W-1:0] rdAddr,
  output logic rdData
);

  lutr_mem_s state;
  lutr_mem_s next_state;

  // load overrides a write in the same cycle
  always_comb begin
    next_state = state;
    if (loadEn) begin
      next_state.cells = loadData;
    end else if (wrEn) begin
      next_state.cells[wrAddr] = wrData;
    end
  end

  // cells keep their contents through reset
  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

  // read follows the address
  assign rdData = state.cells[rdAddr];

endmodule // lutr_mem

`default_nettype wire

// ===== dv/lutr_tile_sva.sv
/* checker for lutr_tile: write pulses, read data, tile flops
   assumes binding to lutr_tile on core_clk */
`timescale 1ns/1ps
`default_nettype none
`include "lutr_cfg.svh"
module lutr_tile_sva
  import lutr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cfgLoad,
  input wire logic cfgMemA,
  input wire logic cfgMemB,
  input wire logic [`LUTR_FUNC_W-1:0] cfgFuncB,
  input wire lutr_org_e cfgOrg,
  input wire lutr_time_e cfgTiming,
  input wire logic cfgClkFall,
  input wire logic tileClk,
  input wire logic [`LUTR_ADDR_W-1:0] lutAAddr,
  input wire logic [`LUTR_ADDR_W-1:0] lutBAddr,
  input wire logic ctrlAPin,
  input wire logic ctrlBPin,
  input wire logic ctrlCPin,
  input wire logic lutAOut,
  input wire logic lutBOut,
  input wire logic tileRegA,
  input wire logic writeSeen
);
  // one clock, one reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_lvl_seen; cfgTiming == LUTR_TIME_LEVEL && ctrlCPin && cfgMemA && !cfgLoad |=> writeSeen; endproperty
  a_lvl_seen: assert property (p_lvl_seen) else $error("no pulse after level write");
  property p_no_we; !ctrlCPin |=> !writeSeen; endproperty
  a_no_we: assert property (p_no_we) else $error("write without enable");
  property p_no_edge; cfgTiming == LUTR_TIME_EDGE && !cfgClkFall && !tileClk |=> !writeSeen; endproperty
  a_no_edge: assert property (p_no_edge) else $error("edge write without tile edge");
  property p_lvl_data;
    cfgTiming == LUTR_TIME_LEVEL && cfgOrg == LUTR_ORG_SPLIT && cfgMemA && ctrlCPin && !cfgLoad ##1 $stable(lutAAddr)
      |-> lutAOut == $past(ctrlAPin);
  endproperty
  a_lvl_data: assert property (p_lvl_data) else $error("written data not read back");
  property p_reg_cap; !cfgClkFall && $rose(tileClk) |=> tileRegA == $past(lutAOut); endproperty
  a_reg_cap: assert property (p_reg_cap) else $error("tile flop missed cell data");
  property p_reg_hold; !tileClk && !$past(tileClk) |=> $stable(tileRegA); endproperty
  a_reg_hold: assert property (p_reg_hold) else $error("tile flop moved without edge");
  property p_deep; cfgOrg == LUTR_ORG_DEEP && cfgMemA && cfgMemB |-> lutBOut == lutAOut; endproperty
  a_deep: assert property (p_deep) else $error("deep outputs differ");
  property p_logic; !cfgMemB |-> lutBOut == cfgFuncB[{ctrlBPin, lutBAddr}]; endproperty
  a_logic: assert property (p_logic) else $error("logic result wrong");
endmodule // lutr_tile_sva
bind lutr_tile lutr_tile_sva u_sva (.core_clk, .rst, .cfgLoad, .cfgMemA, .cfgMemB, .cfgFuncB, .cfgOrg, .cfgTiming,
  .cfgClkFall, .tileClk, .lutAAddr, .lutBAddr, .ctrlAPin, .ctrlBPin, .ctrlCPin, .lutAOut, .lutBOut, .tileRegA,
  .writeSeen);
`default_nettype wire

// ===== dv/lutr_user_model.sv
/* user-side tile clock source, toggling each core cycle while run is set
   assumes core_clk from the bench */
`timescale 1ns/1ps
`default_nettype none
module lutr_user_model (
  input wire logic core_clk,
  input wire logic run,
  output logic tileClk
);
  initial tileClk = 1'b0;
  always @(negedge core_clk) begin
    tileClk <= run ? ~tileClk : 1'b0; // parks low
  end
endmodule // lutr_user_model
`default_nettype wire

// ===== dv/tb_lut_distributed_ram.sv
/* bench for lutr_tile: load, reset, level, edge, deep, dual, logic
   assumes lutr_user_model makes the tile clock */
`timescale 1ns/1ps
`default_nettype none
`include "lutr_cfg.svh"
module tb_lut_distributed_ram
  import lutr_pkg::*;
;
  logic core_clk = 1'h0, rst = 1'h1, cfgLoad = 1'h0, cfgMemA = 1'h1, cfgMemB = 1'h1, cfgClkFall = 1'h0;
  logic cfgSharedAddr = 1'h0, run = 1'h0, ctrlAPin = 1'h0, ctrlBPin = 1'h0, ctrlCPin = 1'h0;
  logic [`LUTR_DEPTH-1:0] cfgInitA = 16'hA5C3, cfgInitB = 16'h0000;
  logic [`LUTR_FUNC_W-1:0] cfgFuncA = 32'h0000FFFF, cfgFuncB = 32'h69960FF0;
  logic [`LUTR_ADDR_W-1:0] lutAAddr = 4'h0, lutBAddr = 4'h0;
  lutr_org_e cfgOrg = LUTR_ORG_SPLIT;
  lutr_time_e cfgTiming = LUTR_TIME_LEVEL;
  wire logic tileClk;
  logic lutAOut, lutBOut, tileRegA, tileRegB, writeSeen;
  int error_cnt = 0, checked = 0;
  always #4 core_clk = ~core_clk;
  lutr_user_model u_user (.core_clk(core_clk), .run(run), .tileClk(tileClk));
  lutr_tile dut (.core_clk(core_clk), .rst(rst), .cfgLoad(cfgLoad), .cfgInitA(cfgInitA), .cfgInitB(cfgInitB),
    .cfgMemA(cfgMemA), .cfgMemB(cfgMemB), .cfgFuncA(cfgFuncA), .cfgFuncB(cfgFuncB), .cfgOrg(cfgOrg),
    .cfgTiming(cfgTiming), .cfgClkFall(cfgClkFall), .cfgSharedAddr(cfgSharedAddr), .tileClk(tileClk),
    .lutAAddr(lutAAddr), .lutBAddr(lutBAddr), .ctrlAPin(ctrlAPin), .ctrlBPin(ctrlBPin), .ctrlCPin(ctrlCPin),
    .lutAOut(lutAOut), .lutBOut(lutBOut), .tileRegA(tileRegA), .tileRegB(tileRegB), .writeSeen(writeSeen));
  // compare one bit
  task chk(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t exp %h got %h", $time, e, g);
    end
  endtask
  // drive generator inputs at the falling edge
  task put(input logic [3:0] a, input logic [3:0] b, input logic dA, input logic dB, input logic we);
    @(negedge core_clk);
    lutAAddr = a;
    lutBAddr = b;
    ctrlAPin = dA;
    ctrlBPin = dB;
    ctrlCPin = we;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'h0;
    @(negedge core_clk) cfgLoad = 1'h1;
    @(negedge core_clk) cfgLoad = 1'h0;
    for (int i = 0; i < 16; i++) begin
      put(i[3:0], i[3:0], 1'h0, 1'h0, 1'h0);
      #1 chk(cfgInitA[i], lutAOut);
      chk(1'h0, lutBOut);
    end
    @(negedge core_clk) rst = 1'h1;
    @(negedge core_clk) rst = 1'h0;
    put(4'h0, 4'h0, 1'h0, 1'h0, 1'h0);
    #1 chk(1'h1, lutAOut);
    $display("test 1 done");
    put(4'h2, 4'h9, 1'h1, 1'h1, 1'h1);
    put(4'h2, 4'h9, 1'h1, 1'h1, 1'h0);
    #1 chk(1'h1, lutAOut);
    chk(1'h1, lutBOut);
    chk(1'h1, writeSeen);
    @(negedge core_clk) cfgSharedAddr = 1'h1;
    put(4'h4, 4'hA, 1'h0, 1'h1, 1'h1);
    put(4'h4, 4'hB, 1'h0, 1'h0, 1'h0);
    #1 chk(1'h1, lutBOut);
    @(negedge core_clk) cfgSharedAddr = 1'h0;
    $display("test 2 done");
    // edge writes wait for the tile edge
    @(negedge core_clk) cfgTiming = LUTR_TIME_EDGE;
    put(4'h5, 4'h5, 1'h1, 1'h1, 1'h1);
    repeat (2) @(negedge core_clk);
    #1 chk(1'h0, lutAOut);
    chk(1'h0, writeSeen);
    @(negedge core_clk) run <= 1'h1;
    repeat (2) @(negedge core_clk);
    run <= 1'h0;
    put(4'h5, 4'h5, 1'h0, 1'h0, 1'h0);
    #1 chk(1'h1, lutAOut);
    chk(1'h1, lutBOut);
    chk(1'h0, writeSeen);
    $display("test 3 done");
    // falling tile edge, flops take old data
    @(negedge core_clk) cfgClkFall = 1'h1;
    put(4'h6, 4'h5, 1'h0, 1'h0, 1'h1);
    @(negedge core_clk) run <= 1'h1;
    repeat (2) @(negedge core_clk);
    run <= 1'h0;
    put(4'h6, 4'h5, 1'h0, 1'h0, 1'h0);
    #1 chk(1'h0, lutAOut);
    chk(1'h0, lutBOut);
    chk(1'h1, tileRegA);
    chk(1'h1, tileRegB);
    chk(1'h1, writeSeen);
    @(negedge core_clk) rst = 1'h1;
    @(negedge core_clk) rst = 1'h0;
    cfgClkFall = 1'h0;
    #1 chk(1'h0, tileRegA);
    chk(1'h0, tileRegB);
    chk(1'h0, lutAOut);
    $display("test 3b done");
    @(negedge core_clk) cfgTiming = LUTR_TIME_LEVEL;
    cfgOrg = LUTR_ORG_DEEP;
    put(4'h3, 4'h0, 1'h1, 1'h1, 1'h1);
    put(4'h3, 4'h0, 1'h0, 1'h1, 1'h0);
    #1 chk(1'h1, lutAOut);
    put(4'h3, 4'h0, 1'h0, 1'h0, 1'h0);
    #1 chk(1'h0, lutAOut);
    $display("test 4 done");
    @(negedge core_clk) cfgOrg = LUTR_ORG_DUAL;
    put(4'hC, 4'h9, 1'h1, 1'h0, 1'h1);
    #1 chk(1'h1, lutBOut);
    put(4'h0, 4'hC, 1'h0, 1'h0, 1'h0);
    #1 chk(1'h1, lutBOut);
    put(4'hC, 4'hC, 1'h0, 1'h0, 1'h1);
    #1 chk(1'h1, lutBOut);
    put(4'hC, 4'hC, 1'h0, 1'h0, 1'h0);
    #1 chk(1'h0, lutBOut);
    chk(1'h0, lutAOut);
    $display("test 5 done");
    @(negedge core_clk) cfgOrg = LUTR_ORG_SPLIT;
    cfgMemB = 1'h0;
    put(4'h5, 4'h5, 1'h1, 1'h1, 1'h1);
    #1 chk(cfgFuncB[21], lutBOut);
    put(4'h5, 4'h5, 1'h1, 1'h0, 1'h0);
    #1 chk(cfgFuncB[5], lutBOut);
    @(negedge core_clk) cfgMemA = 1'h0;
    cfgMemB = 1'h1;
    put(4'h7, 4'h7, 1'h0, 1'h1, 1'h1);
    #1 chk(cfgFuncA[23], lutAOut);
    put(4'h7, 4'h7, 1'h0, 1'h0, 1'h0);
    #1 chk(cfgFuncA[7], lutAOut);
    chk(1'h1, lutBOut);
    @(negedge core_clk) cfgMemA = 1'h1;
    #1 chk(1'h1, lutAOut);
    $display("test 6 done");
    end_of_test;
  end
endmodule // tb_lut_distributed_ram
`default_nettype wire
